// ### src/servo_axis_pkg.sv
/*
 * Shared constants for one servo axis: status qualification timing,
 * parameter indices and reset values, field positions and mode codes.
 * Assumes a 10 MHz system clock; the millisecond base is derived here.
 */

package servo_axis_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_PERIOD_NS  = 1000000;
  localparam int unsigned MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // parameter port indices
  // ****************************************************************
  localparam logic [2:0] IDX_FE_FILTER  = 3'h0;
  localparam logic [2:0] IDX_INP_FILTER = 3'h1;
  localparam logic [2:0] IDX_SPD_FILTER = 3'h2;
  localparam logic [2:0] IDX_TQ_SELECT  = 3'h3;
  localparam logic [2:0] IDX_TQ_CAP     = 3'h4;
  localparam logic [2:0] IDX_UNIT_SEL   = 3'h5;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [15:0] FILTER_RST    = 16'h0000;
  localparam logic [31:0] TQ_SELECT_RST = 32'h0000_0010;
  localparam logic [15:0] TQ_CAP_RST    = 16'h2710; // 1000.0 percent
  localparam logic [31:0] UNIT_SEL_RST  = 32'h0000_0310;

  // ****************************************************************
  // field positions and special values
  // ****************************************************************
  localparam int unsigned TQ_EN_BIT      = 4;
  localparam int unsigned SPD_UNIT_BIT   = 4;
  localparam int unsigned POS_UNIT_LSB   = 8;
  localparam logic [31:0] FE_LEVEL_OFF   = 32'h0FFF_FFFF;
  localparam logic [31:0] INP_RANGE_ALL  = 32'hFFFF_FFFF;
  localparam logic [3:0]  OPMODE_LINEAR  = 4'h4;
  localparam logic [15:0] FILTER_SAT     = 16'hFFFF;

  // ****************************************************************
  // enumerations
  // ****************************************************************
  typedef enum logic [7:0] {
    MODE_NONE = 8'h00,
    MODE_PP   = 8'h01,
    MODE_PV   = 8'h03,
    MODE_TQ   = 8'h04,
    MODE_HM   = 8'h06,
    MODE_CSP  = 8'h08,
    MODE_CSV  = 8'h09,
    MODE_CST  = 8'h0A,
    MODE_PT   = 8'h9B,
    MODE_JG   = 8'h9C
  } mode_e;

  typedef enum logic [1:0] {
    UNIT_MM    = 2'h0,
    UNIT_INCH  = 2'h1,
    UNIT_DEG   = 2'h2,
    UNIT_PULSE = 2'h3
  } pos_unit_e;

endpackage : servo_axis_pkg

// ### src/qualify_timer.sv
/*
 * Millisecond filter timer: a condition must hold without a break for
 * the programmed number of milliseconds before the qualified flag sets.
 * Assumes a one-cycle ms_tick from the same clock domain.
 */
`timescale 1ns/1ps

module qualify_timer
  import servo_axis_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // time base
  input  wire logic        ms_tick,
  // condition and filter time in ms
  input  wire logic        hold_ok,
  input  wire logic [15:0] filter_ms,
  // qualified result
  output logic             qualified_q
);

  logic [15:0] count_q;

  // ****************************************************************
  // elapsed time while the condition holds
  // ****************************************************************
  // saturating so a 65535 ms filter can still be reached
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      count_q <= 16'h0000;
    else if (!hold_ok)
      count_q <= 16'h0000; // RL23
    else if (ms_tick && count_q != FILTER_SAT)
      count_q <= count_q + 16'h0001;
  end

  // flag follows the condition down at once, up only after the filter
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      qualified_q <= 1'b0;
    else
      qualified_q <= hold_ok && (count_q >= filter_ms); // RL23
  end

endmodule : qualify_timer

// ### src/servo_axis_status.sv
/*
 * Status qualification, torque cap and unit selection for one axis.
 * Assumes all inputs come from logic on clk_sys; parameters are written
 * and read through a simple indexed port driven by the axis firmware.
 */
// Function
// (RL1) bit 13 sets after droop stays at/above level for the filter ms
// (RL2) following-error evaluated only in csp, pp, point table and jog
// (RL3) following-error level of 0FFFFFFF keeps that output off
// (RL4) target-reached sets after position gap stays in range for filter time
// (RL5) in-position range at maximum holds target-reached permanently on
// (RL6) in-position qualification only in pp, point table and jog
// (RL7) in pv, target-velocity-reached after speed error stays in range
// (RL8) one-bit torque cap enable, 1 enables, reset value enabled
// (RL9) cap disabled: no cap applied, max torque reads motor maximum
// (RL10) cap is 0.1 percent steps of rated torque, 0.0 to 1000.0
// (RL11) enabled cap of zero gives no torque at all
// (RL12) tool should not write objects mapped into cyclic exchange
// (RL13) speed unit 0 is r/min and ms, 1 is command units, default 1
// (RL14) speed unit picks basic or extension parameter set per object
// (RL15) speed unit applies only in cyclic, profile and point table modes
// (RL16) position unit 0 mm, 1 inch, 2 degree, 3 pulse, default 3
// (RL17) after position unit change the controller must home again
// (RL18) mm or inch outside point table mode raises parameter alarm
// (RL19) degree units with linear motor operation mode raise alarm
// (RL20) degree units refuse a switch into cyclic synchronous modes
// (RL21) degree, fully closed loop and linear load encoder raise alarm
// (RL22) motor speed in pulses is command speed times electronic gear
// (RL23) filter timers restart when condition lapses, bit clears meanwhile
`timescale 1ns/1ps

module servo_axis_status
  import servo_axis_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = MS_CYCLES
)
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // parameter port
  input  wire logic        par_wr,
  input  wire logic        par_rd,
  input  wire logic [2:0]  par_index,
  input  wire logic [31:0] par_wdata,
  output logic [31:0]      par_rdata_q,
  // mode of operation requests from the controller
  input  wire logic        mode_req_valid,
  input  wire logic [7:0]  mode_req,
  output mode_e            active_mode_q,
  output logic             mode_refused_q,
  // settings held by other parameter groups
  input  wire logic [3:0]  operation_mode_field,
  input  wire logic        fully_closed_enable,
  input  wire logic        load_encoder_linear,
  input  wire logic        alarm_reset,
  input  wire logic        homing_done,
  // thresholds
  input  wire logic [31:0] following_error_level,
  input  wire logic [31:0] in_position_range,
  input  wire logic [31:0] speed_window_basic,
  input  wire logic [31:0] speed_window_ext,
  // measured magnitudes
  input  wire logic [31:0] droop_pulses,
  input  wire logic [31:0] position_gap,
  input  wire logic [31:0] speed_error,
  // torque path
  input  wire logic [15:0] motor_max_torque,
  input  wire logic [15:0] torque_demand,
  output logic [15:0]      torque_limit_q,
  output logic [15:0]      torque_out_q,
  // unit dependent sourcing and scaling
  input  wire logic [31:0] basic_value,
  input  wire logic [31:0] ext_value,
  input  wire logic [31:0] speed_cmd_units,
  input  wire logic [15:0] gear_num,
  input  wire logic [15:0] gear_den,
  output logic [31:0]      sourced_value_q,
  output logic [31:0]      motor_speed_pulses_q,
  output logic             speed_unit_cmd_q,
  output pos_unit_e        pos_unit_q,
  // status
  output logic             following_error_q,
  output logic             target_bit_q,
  output logic             param_alarm_q,
  output logic             homing_needed_q
);

  // ****************************************************************
  // helper functions
  // ****************************************************************
  function automatic logic fe_mode(input mode_e m);
    fe_mode = (m == MODE_CSP) || (m == MODE_PP) ||
              (m == MODE_PT) || (m == MODE_JG);
  endfunction : fe_mode

  function automatic logic inp_mode(input mode_e m);
    inp_mode = (m == MODE_PP) || (m == MODE_PT) || (m == MODE_JG);
  endfunction : inp_mode

  // cyclic synchronous, profile and point table positioning modes
  function automatic logic unit_mode(input mode_e m);
    unit_mode = (m == MODE_CSP) || (m == MODE_CSV) || (m == MODE_CST) ||
                (m == MODE_PP) || (m == MODE_PV) || (m == MODE_PT);
  endfunction : unit_mode

  function automatic logic known_mode(input logic [7:0] code);
    case (code)
      MODE_PP, MODE_PV, MODE_TQ, MODE_HM, MODE_CSP,
      MODE_CSV, MODE_CST, MODE_PT, MODE_JG: known_mode = 1'b1;
      default:                              known_mode = 1'b0;
    endcase
  endfunction : known_mode

  function automatic logic csync_mode(input logic [7:0] code);
    csync_mode = (code == MODE_CSP) || (code == MODE_CSV) ||
                 (code == MODE_CST);
  endfunction : csync_mode

  // ****************************************************************
  // stored parameters
  // ****************************************************************
  logic [15:0] fe_filter_q;
  logic [15:0] inp_filter_q;
  logic [15:0] spd_filter_q;
  logic [31:0] tq_select_q;
  logic [15:0] tq_cap_q;
  logic [31:0] unit_sel_q;

  logic        wr_fe;
  logic        wr_inp;
  logic        wr_spd;
  logic        wr_tqs;
  logic        wr_cap;
  logic        wr_unit;

  assign wr_fe   = par_wr && (par_index == IDX_FE_FILTER);
  assign wr_inp  = par_wr && (par_index == IDX_INP_FILTER);
  assign wr_spd  = par_wr && (par_index == IDX_SPD_FILTER);
  assign wr_tqs  = par_wr && (par_index == IDX_TQ_SELECT);
  assign wr_cap  = par_wr && (par_index == IDX_TQ_CAP);
  assign wr_unit = par_wr && (par_index == IDX_UNIT_SEL);

  // filter times, whole 0..65535 ms range
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fe_filter_q  <= FILTER_RST;
      inp_filter_q <= FILTER_RST;
      spd_filter_q <= FILTER_RST;
    end
    else
    begin
      if (wr_fe)
        fe_filter_q <= par_wdata[15:0]; // RL1
      if (wr_inp)
        inp_filter_q <= par_wdata[15:0]; // RL4
      if (wr_spd)
        spd_filter_q <= par_wdata[15:0]; // RL7
    end
  end

  // torque cap selector and value
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tq_select_q <= TQ_SELECT_RST; // RL8
      tq_cap_q    <= TQ_CAP_RST;
    end
    else
    begin
      if (wr_tqs)
        tq_select_q <= par_wdata;
      if (wr_cap)
        tq_cap_q <= par_wdata[15:0];
    end
  end

  // unit selection word
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      unit_sel_q <= UNIT_SEL_RST;
    else if (wr_unit)
      unit_sel_q <= par_wdata;
  end

  logic      tq_enable;
  logic      speed_unit_sel;
  pos_unit_e pos_unit;

  assign tq_enable      = tq_select_q[TQ_EN_BIT]; // RL8
  assign speed_unit_sel = unit_sel_q[SPD_UNIT_BIT]; // RL13
  assign pos_unit       = pos_unit_e'(unit_sel_q[POS_UNIT_LSB +: 2]); // RL16

  // ****************************************************************
  // millisecond time base
  // ****************************************************************
  logic [15:0] ms_count_q;
  logic        ms_tick_q;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ms_count_q <= 16'h0000;
      ms_tick_q  <= 1'b0;
    end
    else if (ms_count_q == 16'(MS_CYCLES_P - 1))
    begin
      ms_count_q <= 16'h0000;
      ms_tick_q  <= 1'b1;
    end
    else
    begin
      ms_count_q <= ms_count_q + 16'h0001;
      ms_tick_q  <= 1'b0;
    end
  end

  // ****************************************************************
  // mode of operation
  // ****************************************************************
  // unknown codes are refused too, so the active mode is always legal
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      active_mode_q  <= MODE_NONE;
      mode_refused_q <= 1'b0;
    end
    else if (mode_req_valid)
    begin
      if (!known_mode(mode_req) ||
          (pos_unit == UNIT_DEG && csync_mode(mode_req))) // RL20
        mode_refused_q <= 1'b1;
      else
      begin
        active_mode_q  <= mode_e'(mode_req);
        mode_refused_q <= 1'b0;
      end
    end
    else
      mode_refused_q <= 1'b0;
  end

  // ****************************************************************
  // status qualification
  // ****************************************************************
  logic        fe_hold;
  logic        inp_hold;
  logic        spd_hold;
  logic        fe_qual;
  logic        inp_qual;
  logic        spd_qual;
  logic        speed_unit_eff;
  logic [31:0] speed_window;

  // speed unit only counts in its own modes; elsewhere basic set applies
  assign speed_unit_eff = speed_unit_sel && unit_mode(active_mode_q); // RL15
  assign speed_window   = speed_unit_eff ? speed_window_ext
                                         : speed_window_basic; // RL14

  assign fe_hold  = fe_mode(active_mode_q) && // RL2
                    (following_error_level != FE_LEVEL_OFF) && // RL3
                    (droop_pulses >= following_error_level); // RL1
  assign inp_hold = inp_mode(active_mode_q) && // RL6
                    (position_gap <= in_position_range); // RL4
  assign spd_hold = (active_mode_q == MODE_PV) && // RL7
                    (speed_error <= speed_window);

  qualify_timer u_fe_timer (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .ms_tick     (ms_tick_q),
    .hold_ok     (fe_hold),
    .filter_ms   (fe_filter_q),
    .qualified_q (fe_qual)
  );

  qualify_timer u_inp_timer (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .ms_tick     (ms_tick_q),
    .hold_ok     (inp_hold),
    .filter_ms   (inp_filter_q),
    .qualified_q (inp_qual)
  );

  qualify_timer u_spd_timer (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .ms_tick     (ms_tick_q),
    .hold_ok     (spd_hold),
    .filter_ms   (spd_filter_q),
    .qualified_q (spd_qual)
  );

  assign following_error_q = fe_qual; // RL1

  // bit 10 means target velocity in pv, target position in pp, point table and jog, else 0
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      target_bit_q <= 1'b0;
    else if (active_mode_q == MODE_PV)
      target_bit_q <= spd_qual; // RL7
    else if (inp_mode(active_mode_q))
      target_bit_q <= inp_qual ||
                      (in_position_range == INP_RANGE_ALL); // RL5
    else
      target_bit_q <= 1'b0; // RL6
  end

  // ****************************************************************
  // torque cap
  // ****************************************************************
  logic [15:0]        cap_limit;
  logic signed [16:0] demand_s;
  logic signed [16:0] limit_s;

  // above the motor maximum the cap is meaningless, so clip to it
  assign cap_limit = !tq_enable ? motor_max_torque : // RL9
                     (tq_cap_q < motor_max_torque) ? tq_cap_q
                                                   : motor_max_torque; // RL10
  assign demand_s  = {torque_demand[15], torque_demand};
  assign limit_s   = {1'b0, cap_limit};

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      torque_limit_q <= 16'h0000;
      torque_out_q   <= 16'h0000;
    end
    else
    begin
      torque_limit_q <= cap_limit;
      if (demand_s > limit_s)
        torque_out_q <= limit_s[15:0]; // RL11
      else if (demand_s < -limit_s)
        torque_out_q <= 16'(-limit_s);
      else
        torque_out_q <= demand_s[15:0];
    end
  end

  // ****************************************************************
  // unit decode, sourcing and gear scaling
  // ****************************************************************
  logic [47:0] gear_product;

  assign gear_product = speed_cmd_units * gear_num; // RL22

  // a zero denominator is a setup fault; hold zero rather than divide
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sourced_value_q      <= 32'h0000_0000;
      motor_speed_pulses_q <= 32'h0000_0000;
      speed_unit_cmd_q     <= 1'b1;
      pos_unit_q           <= UNIT_PULSE;
    end
    else
    begin
      sourced_value_q  <= speed_unit_eff ? ext_value : basic_value; // RL14
      speed_unit_cmd_q <= speed_unit_eff; // RL13
      pos_unit_q       <= pos_unit; // RL16
      if (gear_den == 16'h0000)
        motor_speed_pulses_q <= 32'h0000_0000;
      else
        motor_speed_pulses_q <= 32'(gear_product / gear_den); // RL22
    end
  end

  // ****************************************************************
  // parameter alarm and homing request
  // ****************************************************************
  logic alarm_cond;

  assign alarm_cond =
    ((pos_unit == UNIT_MM || pos_unit == UNIT_INCH) &&
     active_mode_q != MODE_PT) || // RL18
    (pos_unit == UNIT_DEG && operation_mode_field == OPMODE_LINEAR) || // RL19
    (pos_unit == UNIT_DEG && fully_closed_enable &&
     load_encoder_linear); // RL21

  // sticky; a violation present during the reset request still wins
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      param_alarm_q <= 1'b0;
    else if (alarm_cond)
      param_alarm_q <= 1'b1;
    else if (alarm_reset)
      param_alarm_q <= 1'b0;
  end

  // positioning is unsafe until the controller homes in the new unit
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      homing_needed_q <= 1'b0;
    else if (wr_unit &&
             par_wdata[POS_UNIT_LSB +: 2] != unit_sel_q[POS_UNIT_LSB +: 2])
      homing_needed_q <= 1'b1; // RL17
    else if (homing_done)
      homing_needed_q <= 1'b0;
  end

  // ****************************************************************
  // parameter read-back
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      par_rdata_q <= 32'h0000_0000;
    else if (par_rd)
    begin
      case (par_index)
        IDX_FE_FILTER:  par_rdata_q <= {16'h0000, fe_filter_q};
        IDX_INP_FILTER: par_rdata_q <= {16'h0000, inp_filter_q};
        IDX_SPD_FILTER: par_rdata_q <= {16'h0000, spd_filter_q};
        IDX_TQ_SELECT:  par_rdata_q <= tq_select_q;
        IDX_TQ_CAP:     par_rdata_q <= {16'h0000, tq_enable ? tq_cap_q
                                        : motor_max_torque}; // RL9
        IDX_UNIT_SEL:   par_rdata_q <= unit_sel_q;
        default:        par_rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  fe_level_off_a: assert property ( // RL3
    following_error_level == FE_LEVEL_OFF |=> !following_error_q)
    else $error("following error set with level disabled");

  fe_mode_gate_a: assert property ( // RL2
    !fe_mode(active_mode_q) |=> !following_error_q)
    else $error("following error set outside its modes");

  fe_lapse_a: assert property ( // RL23
    droop_pulses < following_error_level |=> !following_error_q)
    else $error("following error held after droop fell");

  pv_speed_lapse_a: assert property ( // RL7
    active_mode_q == MODE_PV && speed_error > speed_window ##1
    active_mode_q == MODE_PV |=> !target_bit_q)
    else $error("velocity reached while error out of window");

  inp_always_on_a: assert property ( // RL5
    inp_mode(active_mode_q) && in_position_range == INP_RANGE_ALL
    |=> target_bit_q)
    else $error("target reached not held at full range");

  torque_zero_a: assert property ( // RL11
    tq_enable && tq_cap_q == 16'h0000 |=> torque_out_q == 16'h0000)
    else $error("torque produced with zero cap");

  cap_read_a: assert property ( // RL9
    par_rd && par_index == IDX_TQ_CAP && !tq_enable
    |=> par_rdata_q == {16'h0000, $past(motor_max_torque)})
    else $error("disabled cap read did not return motor maximum");

  deg_csp_refuse_a: assert property ( // RL20
    mode_req_valid && mode_req == MODE_CSP && pos_unit == UNIT_DEG
    |=> mode_refused_q && $stable(active_mode_q))
    else $error("switch to cyclic position accepted in degrees");

  linear_deg_alarm_a: assert property ( // RL19
    pos_unit == UNIT_DEG && operation_mode_field == OPMODE_LINEAR
    |=> param_alarm_q)
    else $error("no alarm for degrees on linear motor");

  unit_mm_alarm_a: assert property ( // RL18
    (pos_unit == UNIT_MM || pos_unit == UNIT_INCH) &&
    active_mode_q != MODE_PT |=> param_alarm_q)
    else $error("no alarm for length unit outside point table");

endmodule : servo_axis_status

// ### testbench/motion_ctrl_model.sv
/* controller model: issues mode requests over the cyclic exchange.
   assumes the bench clock; drives just after falling edges. */
`timescale 1ns/1ps
module motion_ctrl_model
(
  // clock
  input  wire logic clk_sys,
  // request toward the axis
  output logic       mode_req_valid,
  output logic [7:0] mode_req
);
  // idle request lines at time zero
  initial
  begin
    mode_req_valid = 1'h0;
    mode_req = 8'hA5;
  end
  // one-cycle request; the code is inverted once released so a stale
  // value is never mistaken for a held one
  task automatic send(input logic [7:0] code);
    @(negedge clk_sys);
    mode_req_valid = 1'h1;
    mode_req = code;
    @(negedge clk_sys);
    mode_req_valid = 1'h0;
    mode_req = ~code;
  endtask : send
endmodule : motion_ctrl_model

// ### testbench/tb.sv
/* bench for servo_axis_status: mode table, then hand cases.
   assumes a 4-cycle ms tick and inputs moved at falling edges. */
`timescale 1ns/1ps
module tb import servo_axis_pkg::*;;
  logic clk_sys = 1'h0, reset_n = 1'h0, par_wr = 1'h0, par_rd = 1'h0;
  logic alarm_reset = 1'h0, homing_done = 1'h0;
  logic fully_closed_enable = 1'h0, load_encoder_linear = 1'h0;
  logic [2:0] par_index = 3'h0;
  logic [3:0] operation_mode_field = 4'h0;
  logic [7:0] mode_req;
  logic mode_req_valid, mode_refused_q, speed_unit_cmd_q;
  logic following_error_q, target_bit_q, param_alarm_q, homing_needed_q;
  logic [15:0] motor_max_torque = 16'h3000, torque_demand = 16'h0320;
  logic [15:0] gear_num = 16'h0002, gear_den = 16'h0001;
  logic [15:0] torque_limit_q, torque_out_q;
  logic [31:0] par_wdata = 32'h0, par_rdata_q, sourced_value_q;
  logic [31:0] motor_speed_pulses_q, speed_error = 32'h0;
  logic [31:0] following_error_level = 32'h64, in_position_range = 32'h0;
  logic [31:0] speed_window_basic = 32'h5, speed_window_ext = 32'h7;
  logic [31:0] droop_pulses = 32'hC8, position_gap = 32'h3E8;
  logic [31:0] basic_value = 32'h11, ext_value = 32'h22;
  logic [31:0] speed_cmd_units = 32'h10;
  mode_e active_mode_q;
  pos_unit_e pos_unit_q;
  int fails = 0, checks = 0;
  // mode code with bit 8 set where the following-error bit may show
  logic [8:0] rows [9] = '{9'h108, 9'h101, 9'h19B, 9'h19C,
                          9'h003, 9'h004, 9'h006, 9'h009, 9'h00A};

  // short ms tick keeps the filter waits brief
  servo_axis_status #(.MS_CYCLES_P(4)) servo_axis_status_i (.*);
  motion_ctrl_model motion_ctrl_model_i (.clk_sys(clk_sys),
    .mode_req_valid(mode_req_valid), .mode_req(mode_req));

  // 100 ns clock
  always #50 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  // tool port; it leaves objects the controller maps cyclically alone
  task automatic wr(input logic [2:0] i, input logic [31:0] d);
    @(negedge clk_sys);
    par_wr = 1'h1;
    par_index = i;
    par_wdata = d;
    @(negedge clk_sys);
    par_wr = 1'h0;
  endtask : wr
  task automatic rd(input logic [2:0] i, input logic [31:0] exp);
    @(negedge clk_sys);
    par_rd = 1'h1;
    par_index = i;
    @(negedge clk_sys);
    par_rd = 1'h0;
    chk(par_rdata_q, exp);
  endtask : rd
  task automatic pulse_clear();
    alarm_reset = 1'h1;
    cyc(1);
    alarm_reset = 1'h0;
    cyc(1);
  endtask : pulse_clear
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial
  begin
    cyc(2);
    chk(speed_unit_cmd_q, 1);
    chk(pos_unit_q, 3);
    reset_n = 1'h1;
    rd(IDX_TQ_SELECT, 32'h10);
    rd(IDX_UNIT_SEL, 32'h310);
    rd(IDX_FE_FILTER, 32'h0);
    foreach (rows[k])
    begin
      motion_ctrl_model_i.send(rows[k][7:0]);
      chk(active_mode_q, rows[k][7:0]);
      cyc(2);
      chk(following_error_q, rows[k][8]);
    end
    // 0FFFFFFF level turns the output off even far past it
    motion_ctrl_model_i.send(8'h08);
    following_error_level = 32'h0FFFFFFF;
    droop_pulses = 32'hFFFFFFFF;
    cyc(3);
    chk(following_error_q, 0);
    chk(speed_unit_cmd_q, 1);
    chk(sourced_value_q, 32'h22);
    chk(motor_speed_pulses_q, 32'h20);
    // two ms filter: no early set, bounded rise, drop on lapse
    following_error_level = 32'h64;
    droop_pulses = 32'h0;
    wr(IDX_FE_FILTER, 32'h2);
    droop_pulses = 32'hC8;
    cyc(3);
    chk(following_error_q, 0);
    repeat (16) if (following_error_q !== 1'h1) cyc(1);
    chk(following_error_q, 1);
    droop_pulses = 32'h0;
    cyc(2);
    chk(following_error_q, 0);
    // unit checks and alarms in profile position
    motion_ctrl_model_i.send(8'h01);
    wr(IDX_UNIT_SEL, 32'h010);
    cyc(2);
    chk(param_alarm_q, 1);
    chk(pos_unit_q, 0);
    chk(homing_needed_q, 1);
    // the controller homes again in the new unit before positioning
    homing_done = 1'h1;
    cyc(1);
    homing_done = 1'h0;
    chk(homing_needed_q, 0);
    wr(IDX_UNIT_SEL, 32'h210);
    chk(homing_needed_q, 1);
    pulse_clear();
    chk(param_alarm_q, 0);
    motion_ctrl_model_i.send(8'h08);
    chk(mode_refused_q, 1);
    chk(active_mode_q, 8'h01);
    operation_mode_field = 4'h4;
    cyc(2);
    chk(param_alarm_q, 1);
    operation_mode_field = 4'h0;
    pulse_clear();
    fully_closed_enable = 1'h1;
    load_encoder_linear = 1'h1;
    pulse_clear();
    chk(param_alarm_q, 1);
    // torque cap: zero, partial, then disabled
    wr(IDX_TQ_CAP, 32'h0);
    cyc(1);
    chk(torque_out_q, 16'h0);
    wr(IDX_TQ_CAP, 32'h1F4);
    cyc(1);
    chk(torque_out_q, 16'h1F4);
    chk(torque_limit_q, 16'h1F4);
    wr(IDX_TQ_SELECT, 32'h0);
    rd(IDX_TQ_CAP, 32'h3000);
    chk(torque_out_q, 16'h320);
    chk(torque_limit_q, 16'h3000);
    in_position_range = 32'hFFFFFFFF;
    cyc(3);
    chk(target_bit_q, 1);
    // one ms in-position filter: drop on lapse, rise only after a tick
    wr(IDX_INP_FILTER, 32'h1);
    in_position_range = 32'h3E7;
    cyc(2);
    chk(target_bit_q, 0);
    in_position_range = 32'h3E8;
    cyc(2);
    chk(target_bit_q, 0);
    repeat (12) if (target_bit_q !== 1'h1) cyc(1);
    chk(target_bit_q, 1);
    // homing mode: no in-position bit, basic speed set
    motion_ctrl_model_i.send(8'h06);
    cyc(1);
    chk(target_bit_q, 0);
    chk(speed_unit_cmd_q, 0);
    chk(sourced_value_q, 32'h11);
    // profile velocity against the extension window of 7, not basic 5
    motion_ctrl_model_i.send(8'h03);
    speed_error = 32'h6;
    cyc(2);
    chk(target_bit_q, 1);
    speed_error = 32'h8;
    cyc(2);
    chk(target_bit_q, 0);
    // reset in mid-run brings the defaults back
    reset_n = 1'h0;
    cyc(2);
    chk(pos_unit_q, 3);
    chk(param_alarm_q, 0);
    reset_n = 1'h1;
    rd(IDX_TQ_SELECT, 32'h10);
    report_and_stop();
  end

  // watchdog at 4000 cycles, well beyond the hundred or so cycles the tests need
  initial
  begin
    #400000;
    fails++;
    report_and_stop();
  end
endmodule : tb
